// File: hw/boot_zone_config.sv
`timescale 1ns/1ps
`include "boot_zone_map.svh"


module boot_zone_config
  import boot_zone_pkg::*;
#(
  parameter int NGPIO = 64,
  parameter int NLS = 8,
  parameter int NSECT = 16,
  parameter int LPW = 30
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  // pins from outside the clock domain
  input wire logic emu_connected_i,
  input wire logic sel_pin0_i,
  input wire logic sel_pin1_i,
  input wire logic [NGPIO-1:0] gpio_i,
  // debugger access to the emulation boot pin configuration
  input wire logic emu_cfg_wr_i,
  input wire logic [31:0] emu_cfg_data_i,
  output logic [31:0] emulation_boot_pin_config_o,
  input wire logic [63:0] emu_boot_definition_table_i,
  // reset vector fetch
  output logic vec_fetch_o,
  input wire logic [`PC_W-1:0] vec_data_i,
  output logic [`PC_W-1:0] pc_o,
  // interrupt gating
  input wire logic irq_enable_i,
  output logic pie_enable_o,
  output logic master_int_enable_o,
  // otp port, read data one cycle after otp_rd_o
  output logic otp_rd_o,
  output logic otp_wr_o,
  output logic [15:0] otp_addr_o,
  output logic [31:0] otp_wdata_o,
  input wire logic [31:0] otp_data_i,
  // otp program request
  input wire logic prog_req_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [31:0] prog_data_i,
  // password key registers
  input wire logic key_wr_i,
  input wire logic [2:0] key_sel_i,
  input wire logic [31:0] key_data_i,
  // boot result
  output logic boot_done_o,
  output logic boot_wait_o,
  output boot_zone_pkg::boot_flow_t boot_flow_o,
  output logic [7:0] boot_mode_o,
  output logic [3:0] mode_count_o,
  // zone security state
  output logic [1:0] zone_locked_o,
  output logic [NLS-1:0] ls_zone2_o,
  output logic [NLS-1:0] ls_secure_o,
  output logic [NSECT-1:0] flash_zone2_o,
  output logic [NSECT-1:0] flash_secure_o
);

  import boot_zone_pkg::*;

  localparam int NRES = NLS + NSECT;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NGPIO+2:0] pin_s1_r;
  logic [NGPIO+2:0] pin_s2_r;

  always_ff @(posedge clk_i)
  begin
    pin_s1_r <= {emu_connected_i, sel_pin1_i, sel_pin0_i, gpio_i};
    pin_s2_r <= pin_s1_r;
  end

  wire emu_present = pin_s2_r[NGPIO+2];
  wire [1:0] sel_pins = pin_s2_r[NGPIO+1:NGPIO];
  wire [NGPIO-1:0] gpio_sync = pin_s2_r[NGPIO-1:0];

  ////////////////////////////////////////////////////////////////////////
  // emulation config word: kept over reset_i so the debugger's value
  // steers the next boot; only power-on clears it
  logic [31:0] emu_cfg_r;

  always_ff @(posedge clk_i)
  begin
    if (por_i)
      emu_cfg_r <= 32'h00000000;
    else if (emu_cfg_wr_i)
      emu_cfg_r <= emu_cfg_data_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  boot_state_t state_r;
  boot_state_t state_nxt;
  logic [4:0] step_r;
  logic phase_r;
  logic [LPW-1:0] lp_r [0:1];
  logic [31:0] zw_r [0:17];
  logic [31:0] prog_cur_r;
  logic [1:0] locked_nxt;

  // one decoder per zone link pointer
  logic [4:0] region1;
  logic [4:0] region2;

  link_pointer_decoder #(.LPW(LPW)) u_lp1 (
    .lp_i(lp_r[0]),
    .region_o(region1)
  );

  link_pointer_decoder #(.LPW(LPW)) u_lp2 (
    .lp_i(lp_r[1]),
    .region_o(region2)
  );

  // address of the current read step
  wire in_z2 = (step_r >= `STEP_Z2);
  wire [4:0] word_step = in_z2 ? step_r - `STEP_Z2 : step_r - `STEP_Z1;
  wire [15:0] z1_base = 16'(`OTP_Z1_BASE + 16'(region1) * `REGION_WORDS);
  wire [15:0] z2_base = 16'(`OTP_Z2_BASE + 16'(region2) * `REGION_WORDS);
  wire [15:0] zone_addr = (in_z2 ? z2_base : z1_base) + 16'(word_step);
  wire [15:0] step_addr = (step_r == 5'h00) ? `OTP_LP_Z1 :
                          (step_r == 5'h01) ? `OTP_LP_Z2 : zone_addr;
  wire [4:0] zw_idx = in_z2 ? word_step + 5'(`WORDS_PER_ZONE) : word_step;
  wire read_last = phase_r && (step_r == `STEP_LAST);

  // key decode of the debugger word, needed by the next-state logic
  wire [7:0] emu_key = emu_cfg_r[`KEY_MSB:`KEY_LSB];
  wire key_emu = (emu_key == `KEY_EMU);
  wire key_sa = (emu_key == `KEY_STANDALONE);
  wire wait_sel = emu_present && !key_emu && !key_sa;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_VEC_FETCH: state_nxt = ST_VEC_LOAD;
      ST_VEC_LOAD: state_nxt = ST_OTP_READ;
      ST_OTP_READ: if (read_last) state_nxt = ST_DECIDE;
      ST_DECIDE: state_nxt = wait_sel ? ST_WAIT : ST_DONE;
      ST_DONE: if (prog_req_i) state_nxt = ST_PROG_RD;
      ST_WAIT: state_nxt = ST_WAIT;
      ST_PROG_RD: state_nxt = ST_PROG_CAP;
      ST_PROG_CAP: state_nxt = ST_PROG_WR;
      ST_PROG_WR: state_nxt = ST_DONE;
      default: state_nxt = ST_VEC_FETCH;
    endcase
  end

  // state, step counter and read phase
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= ST_VEC_FETCH;
      step_r <= 5'h00;
      phase_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= (state_r == ST_OTP_READ) && !phase_r;
      if (state_r == ST_OTP_READ && phase_r)
        step_r <= step_r + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset vector fetch and program counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc_o <= `RESET_VECTOR;
      vec_fetch_o <= 1'b0;
    end
    else
    begin
      vec_fetch_o <= (state_r == ST_VEC_FETCH);
      // the vector arrives one cycle after the strobe is seen
      if (state_r == ST_OTP_READ && step_r == 5'h00 && !phase_r)
        pc_o <= vec_data_i;
    end
  end

  // interrupts held off until boot selection has finished
  wire irq_on = (state_nxt == ST_DONE) && irq_enable_i;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pie_enable_o <= 1'b0;
      master_int_enable_o <= 1'b0;
    end
    else
    begin
      pie_enable_o <= irq_on;
      master_int_enable_o <= irq_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address for the step about to be issued
  wire [4:0] step_after = step_r + 5'h01;
  wire [15:0] step_addr_after = (step_after == 5'h01) ? `OTP_LP_Z2 :
    ((step_after >= `STEP_Z2) ?
     z2_base + 16'(step_after - `STEP_Z2) :
     z1_base + 16'(step_after - `STEP_Z1));
  wire [15:0] step_addr_next = (state_r == ST_OTP_READ) ?
    step_addr_after : step_addr;

  // otp port; a program write never raises a bit already at zero
  wire otp_issue = (state_r == ST_OTP_READ) && !phase_r;
  wire prog_issue = (state_r == ST_DONE) && prog_req_i;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      otp_rd_o <= 1'b0;
      otp_wr_o <= 1'b0;
      otp_addr_o <= 16'h0000;
      otp_wdata_o <= 32'hFFFFFFFF;
    end
    else
    begin
      otp_rd_o <= (state_nxt == ST_OTP_READ && !(otp_issue)) ||
                  prog_issue;
      otp_wr_o <= (state_r == ST_PROG_WR);
      if (prog_issue)
        otp_addr_o <= prog_addr_i;
      else if (state_nxt == ST_OTP_READ)
        otp_addr_o <= otp_issue ? otp_addr_o : step_addr_next;
      if (state_r == ST_PROG_WR)
        otp_wdata_o <= prog_cur_r & prog_data_i;
    end
  end

  // capture of link pointers, zone words and the word being programmed
  always_ff @(posedge clk_i)
  begin
    if (state_r == ST_OTP_READ && phase_r)
    begin
      if (step_r < `STEP_Z1)
        lp_r[step_r[0]] <= otp_data_i[LPW-1:0];
      else
        zw_r[zw_idx] <= otp_data_i;
    end
    // read data stands one cycle after the strobe, so take it here
    if (state_r == ST_PROG_CAP)
      prog_cur_r <= otp_data_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // boot selection
  wire [31:0] z1_pin_cfg = zw_r[`W_BOOTPIN];
  wire [63:0] z1_def = {zw_r[`W_DEFHI], zw_r[`W_DEFLO]};
  wire use_emu = emu_present && key_emu;
  wire z1_valid = (z1_pin_cfg[`KEY_MSB:`KEY_LSB] == `KEY_EMU);

  // resolver input: emulation word or zone-1 otp word
  wire [23:0] res_cfg = use_emu ? emu_cfg_r[`FIELDS_MSB:0] :
                                  z1_pin_cfg[`FIELDS_MSB:0];
  wire [63:0] res_def = use_emu ? emu_boot_definition_table_i : z1_def;
  logic [7:0] res_mode;
  logic [1:0] res_used;

  mode_select_resolver #(.NGPIO(NGPIO)) u_res (
    .cfg_i(res_cfg),
    .pins_i(gpio_sync),
    .def_i(res_def),
    .mode_o(res_mode),
    .used_o(res_used)
  );

  // two-pin default table, used when the emulation word is not in use and zone-1 has no valid config
  wire [7:0] pin_mode = (sel_pins == 2'b00) ? `MODE_PARALLEL :
                        (sel_pins == 2'b01) ? `MODE_SCI :
                        (sel_pins == 2'b10) ? `MODE_CAN : `MODE_FLASH;
  wire use_pins = !use_emu && !z1_valid;
  wire [7:0] mode_sel = use_pins ? pin_mode : res_mode;
  wire [3:0] count_sel = use_pins ? 4'h4 : 4'(4'h1 << res_used);
  wire [2:0] flow_sel = wait_sel ? FLOW_WAIT :
                        use_emu ? FLOW_EMU :
                        (emu_present && key_sa) ? FLOW_EMU_STANDALONE :
                        use_pins ? FLOW_STANDALONE_PINS :
                        FLOW_STANDALONE_OTP;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      boot_flow_o <= FLOW_NONE;
      boot_mode_o <= 8'h00;
      mode_count_o <= 4'h0;
    end
    else if (state_r == ST_DECIDE)
    begin
      boot_flow_o <= boot_flow_t'(flow_sel);
      boot_mode_o <= wait_sel ? 8'h00 : mode_sel;
      mode_count_o <= wait_sel ? 4'h0 : count_sel;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      boot_done_o <= 1'b0;
      boot_wait_o <= 1'b0;
    end
    else
    begin
      boot_done_o <= (state_nxt == ST_DONE) || boot_done_o;
      boot_wait_o <= (state_nxt == ST_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // password key registers, written by software
  logic [31:0] key_r [0:7];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 8; i++)
        key_r[i] <= 32'h00000000;
    end
    else if (key_wr_i)
      key_r[key_sel_i] <= key_data_i;
  end

  // a zone with all password bits still at one is blank, hence open
  for (genvar z = 0; z < 2; z++)
  begin : g_zone
    localparam int B = z * 9;
    wire [127:0] pw = {zw_r[B+3], zw_r[B+2], zw_r[B+1], zw_r[B]};
    wire [127:0] key = {key_r[z*4+3], key_r[z*4+2],
                        key_r[z*4+1], key_r[z*4]};
    wire blank = &pw;
    assign locked_nxt[z] = !blank && (key != pw);
  end

  ////////////////////////////////////////////////////////////////////////
  // resource claims: a programmed zero claims; zone 1 wins a conflict
  wire [NRES-1:0] claim1 = ~{zw_r[`W_FLALLOC][NSECT-1:0],
                             zw_r[`W_LSALLOC][NLS-1:0]};
  wire [NRES-1:0] claim2 = ~{zw_r[9+`W_FLALLOC][NSECT-1:0],
                             zw_r[9+`W_LSALLOC][NLS-1:0]};
  wire loaded = (state_r == ST_DONE) || (state_r == ST_WAIT) ||
                (state_r >= ST_PROG_RD);
  logic [NRES-1:0] owner2;
  logic [NRES-1:0] secure;

  // per-resource owner and secure bit; locked until otp is loaded
  for (genvar r = 0; r < NRES; r++)
  begin : g_res
    assign owner2[r] = claim2[r] && !claim1[r];
    assign secure[r] = !loaded ||
                       (claim1[r] && locked_nxt[0]) ||
                       (owner2[r] && locked_nxt[1]);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      zone_locked_o <= 2'b11;
      ls_zone2_o <= '0;
      ls_secure_o <= '1;
      flash_zone2_o <= '0;
      flash_secure_o <= '1;
    end
    else
    begin
      zone_locked_o <= loaded ? locked_nxt : 2'b11;
      ls_zone2_o <= owner2[NLS-1:0];
      ls_secure_o <= secure[NLS-1:0];
      flash_zone2_o <= owner2[NRES-1:NLS];
      flash_secure_o <= secure[NRES-1:NLS];
    end
  end

  assign emulation_boot_pin_config_o = emu_cfg_r;

endmodule // boot_zone_config

// File: hw/boot_zone_map.svh
`ifndef BOOT_ZONE_MAP_SVH
`define BOOT_ZONE_MAP_SVH

// reset vector location and width of the program counter
`define RESET_VECTOR 22'h3FFFC0
`define PC_W 22

// key field and mode-select fields of a boot pin configuration word
`define KEY_MSB 31
`define KEY_LSB 24
`define FIELDS_MSB 23
`define FIELD_W 8
`define FIELD_COUNT 3
`define KEY_EMU 8'h5A
`define KEY_STANDALONE 8'hA5
`define FIELD_UNUSED 8'hFF

// otp map: link pointers, zone region bases and region stride
`define OTP_LP_Z1 16'h0000
`define OTP_LP_Z2 16'h0001
`define OTP_Z1_BASE 16'h0020
`define OTP_Z2_BASE 16'h0400
`define REGION_WORDS 16'h0010

// word offsets inside one zone region
`define W_PW0 4'h0
`define W_LSALLOC 4'h4
`define W_FLALLOC 4'h5
`define W_BOOTPIN 4'h6
`define W_DEFLO 4'h7
`define W_DEFHI 4'h8
`define WORDS_PER_ZONE 4'h9

// read sequence: two link pointers then nine words per zone
`define STEP_Z1 5'h02
`define STEP_Z2 5'h0B
`define STEP_LAST 5'h13

// boot modes chosen by the two selection pins
`define MODE_PARALLEL 8'h00
`define MODE_SCI 8'h01
`define MODE_CAN 8'h02
`define MODE_FLASH 8'h03

`endif

// File: hw/boot_zone_pkg.sv
package boot_zone_pkg;

  // boot sequencer states
  typedef enum logic [3:0] {
    ST_VEC_FETCH,
    ST_VEC_LOAD,
    ST_OTP_READ,
    ST_DECIDE,
    ST_DONE,
    ST_WAIT,
    ST_PROG_RD,
    ST_PROG_CAP,
    ST_PROG_WR
  } boot_state_t;

  // flow the boot selection took
  typedef enum logic [2:0] {
    FLOW_NONE,
    FLOW_EMU,
    FLOW_EMU_STANDALONE,
    FLOW_STANDALONE_OTP,
    FLOW_STANDALONE_PINS,
    FLOW_WAIT
  } boot_flow_t;

endpackage

// File: hw/link_pointer_decoder.sv
`timescale 1ns/1ps
`include "boot_zone_map.svh"

module link_pointer_decoder #(
  parameter int LPW = 30
) (
  // link pointer word read from otp
  input wire logic [LPW-1:0] lp_i,
  // active region number, zero for the base region
  output logic [4:0] region_o
);

  // all bits looked at together; the highest zero wins
  always_comb
  begin
    region_o = 5'h00;
    for (int i = 0; i < LPW; i++)
    begin
      if (!lp_i[i])
        region_o = 5'(i + 1);
    end
  end

endmodule // link_pointer_decoder

// File: hw/mode_select_resolver.sv
`timescale 1ns/1ps
`include "boot_zone_map.svh"

module mode_select_resolver #(
  parameter int NGPIO = 64
) (
  // mode-select fields and sampled pins
  input wire logic [23:0] cfg_i,
  input wire logic [NGPIO-1:0] pins_i,
  // eight boot-definition entries, entry 0 in the low byte
  input wire logic [63:0] def_i,
  // chosen boot mode and number of fields in use
  output logic [7:0] mode_o,
  output logic [1:0] used_o
);

  localparam int SELW = $clog2(NGPIO);

  logic [2:0] used;
  logic [2:0] bits;
  logic [2:0] idx;

  // per-field decode: all-ones marks the field unused
  for (genvar f = 0; f < `FIELD_COUNT; f++)
  begin : g_field
    wire [7:0] fv = cfg_i[f*`FIELD_W +: `FIELD_W];
    assign used[f] = (fv != `FIELD_UNUSED);
    assign bits[f] = pins_i[fv[SELW-1:0]];
  end

  // pack used fields, lowest field lowest; unused upper bits stay 0
  always_comb
  begin
    int pos;
    pos = 0;
    idx = 3'h0;
    for (int f = 0; f < `FIELD_COUNT; f++)
    begin
      if (used[f])
      begin
        idx[pos] = bits[f];
        pos = pos + 1;
      end
    end
    used_o = 2'(pos);
  end

  assign mode_o = def_i[{idx, 3'h0} +: 8];

endmodule // mode_select_resolver

// File: verification/boot_zone_chk.sv
`timescale 1ns/1ps
`include "boot_zone_map.svh"

module boot_zone_chk
  import boot_zone_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire logic emu_connected_i,
  input wire logic [31:0] otp_data_i,
  // watched outputs
  input wire logic [31:0] emulation_boot_pin_config_o,
  input wire logic vec_fetch_o,
  input wire logic [`PC_W-1:0] pc_o,
  input wire logic pie_enable_o,
  input wire logic master_int_enable_o,
  input wire logic otp_rd_o,
  input wire logic otp_wr_o,
  input wire logic [15:0] otp_addr_o,
  input wire logic [31:0] otp_wdata_o,
  input wire logic boot_done_o,
  input wire logic boot_wait_o,
  input wire boot_zone_pkg::boot_flow_t boot_flow_o,
  input wire logic [7:0] boot_mode_o,
  input wire logic [3:0] mode_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////
  // key and count of used fields, taken from the debugger word readback
  logic [7:0] key;
  logic [1:0] used_n;
  assign key = emulation_boot_pin_config_o[31:24];
  assign used_n = {1'b0, emulation_boot_pin_config_o[23:16] != 8'hFF}
    + {1'b0, emulation_boot_pin_config_o[15:8] != 8'hFF}
    + {1'b0, emulation_boot_pin_config_o[7:0] != 8'hFF};

  ////////////////////////////////////////////////////////////////////////////
  // boot flow checks; the pc check ignores the default disable on purpose
  a_irq_held_off: assert property (
    !boot_done_o |-> !pie_enable_o && !master_int_enable_o)
    else $error("interrupt enable seen before boot finished");
  a_pc_at_vector: assert property (disable iff (1'b0)
    reset_i |=> pc_o == `RESET_VECTOR)
    else $error("pc not at reset vector after reset");
  a_fetch_on_release: assert property (
    $fell(reset_i) |-> ##[0:2] (vec_fetch_o && pc_o == `RESET_VECTOR))
    else $error("no vector fetch after reset release");
  a_wait_bad_key: assert property (
    $rose(boot_wait_o) |-> emu_connected_i && key != `KEY_EMU
      && key != `KEY_STANDALONE && mode_count_o == 4'h0)
    else $error("wait mode entered without a bad key");
  a_wait_stays: assert property (
    boot_wait_o |=> boot_wait_o && !boot_done_o && boot_flow_o == FLOW_WAIT)
    else $error("wait mode left before reset");
  a_emu_key_count: assert property (
    boot_done_o && boot_flow_o == FLOW_EMU |-> key == `KEY_EMU
      && emu_connected_i && mode_count_o == (4'h1 << used_n))
    else $error("emulation flow key or mode count wrong");
  a_emu_standalone: assert property (
    boot_done_o && boot_flow_o == FLOW_EMU_STANDALONE
      |-> key == `KEY_STANDALONE && emu_connected_i)
    else $error("emulated stand-alone flow without its key");
  a_no_emu_flow: assert property (
    boot_done_o && !emu_connected_i
      |-> boot_flow_o inside {FLOW_STANDALONE_OTP, FLOW_STANDALONE_PINS})
    else $error("stand-alone flow not taken without emulator");
  a_pin_modes: assert property (
    boot_done_o && boot_flow_o == FLOW_STANDALONE_PINS
      |-> mode_count_o == 4'h4 && boot_mode_o[7:2] == 6'h0)
    else $error("pin flow mode out of range");
  a_otp_clear_only: assert property (
    otp_wr_o |-> $past(otp_rd_o, 3) && $past(otp_addr_o, 3) == otp_addr_o
      && (otp_wdata_o & ~$past(otp_data_i, 2)) == 32'h0)
    else $error("otp write would set a cleared bit");

  // main scenarios reached
  c_wait: cover property (boot_wait_o);
  c_emu: cover property (boot_done_o && boot_flow_o == FLOW_EMU);
  c_pins: cover property (boot_done_o && boot_flow_o == FLOW_STANDALONE_PINS);
  c_prog: cover property (otp_wr_o);
endmodule // boot_zone_chk

bind boot_zone_config boot_zone_chk u_chk (.clk_i, .reset_i,
  .emu_connected_i, .otp_data_i, .emulation_boot_pin_config_o, .vec_fetch_o,
  .pc_o, .pie_enable_o, .master_int_enable_o, .otp_rd_o, .otp_wr_o,
  .otp_addr_o, .otp_wdata_o, .boot_done_o, .boot_wait_o, .boot_flow_o,
  .boot_mode_o, .mode_count_o);

// File: verification/otp_vec_model.sv
`timescale 1ns/1ps

module otp_vec_model #(
  parameter logic [21:0] VEC = 22'h01A2B3
) (
  // clock
  input wire logic clk_i,
  // reset vector port
  input wire logic vec_fetch_i,
  output logic [21:0] vec_data_o,
  // otp port
  input wire logic otp_rd_i,
  input wire logic otp_wr_i,
  input wire logic [15:0] otp_addr_i,
  input wire logic [31:0] otp_wdata_i,
  output logic [31:0] otp_data_o
);
  logic [31:0] mem [0:2047];

  ////////////////////////////////////////////////////////////////////////////
  // blank otp reads all ones
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 32'hFFFFFFFF;
  end

  // data is valid one cycle only; otherwise it toggles so stale reads show
  always @(posedge clk_i)
  begin
    vec_data_o <= vec_fetch_i ? VEC : ~vec_data_o;
    otp_data_o <= otp_rd_i ? mem[otp_addr_i[10:0]] : ~otp_data_o;
    if (otp_wr_i)
      mem[otp_addr_i[10:0]] <= mem[otp_addr_i[10:0]] & otp_wdata_i;
  end
endmodule // otp_vec_model

// File: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  import boot_zone_pkg::*;
  localparam logic [21:0] VEC = 22'h01A2B3;
  logic clk_i, reset_i, por_i, emu_connected_i, sel_pin0_i, sel_pin1_i;
  logic emu_cfg_wr_i, prog_req_i, key_wr_i, irq_enable_i;
  logic vec_fetch_o, otp_rd_o, otp_wr_o, boot_done_o, boot_wait_o;
  logic pie_enable_o, master_int_enable_o;
  logic [63:0] gpio_i, emu_boot_definition_table_i;
  logic [31:0] emu_cfg_data_i, prog_data_i, key_data_i, otp_data_i;
  logic [31:0] emulation_boot_pin_config_o, otp_wdata_o;
  logic [15:0] prog_addr_i, otp_addr_o;
  logic [21:0] vec_data_i, pc_o;
  logic [2:0] key_sel_i;
  boot_flow_t boot_flow_o;
  logic [7:0] boot_mode_o, ls_zone2_o, ls_secure_o;
  logic [15:0] flash_zone2_o, flash_secure_o;
  logic [3:0] mode_count_o;
  logic [1:0] zone_locked_o;
  int mismatches, checked;

  ////////////////////////////////////////////////////////////////////////////
  boot_zone_config DUT (.*);
  otp_vec_model #(.VEC(VEC)) u_otp (.clk_i(clk_i), .vec_fetch_i(vec_fetch_o),
    .vec_data_o(vec_data_i), .otp_rd_i(otp_rd_o), .otp_wr_i(otp_wr_o),
    .otp_addr_i(otp_addr_o), .otp_wdata_i(otp_wdata_o),
    .otp_data_o(otp_data_i));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs move 1 ns after the edge so no race with the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // word and pins change under reset, so no stale result is ever judged
  task automatic boot(input logic [31:0] cfg, input logic emu,
    input logic [1:0] pins);
    int n;
    n = 0;
    reset_i = 1'b1;
    emu_connected_i = emu;
    {sel_pin1_i, sel_pin0_i} = pins;
    emu_cfg_data_i = cfg;
    emu_cfg_wr_i = 1'b1;
    tick(1);
    emu_cfg_wr_i = 1'b0;
    tick(3);
    reset_i = 1'b0;
    while (!(boot_done_o === 1'b1 || boot_wait_o === 1'b1) && n < 200)
    begin
      tick(1);
      n++;
    end
    chk(32'(n < 200), 32'h1);
    tick(1);
  endtask

  task automatic expect_boot(input boot_flow_t f, input logic [7:0] m,
    input logic [3:0] c);
    chk(32'(boot_flow_o), 32'(f));
    chk({24'h0, boot_mode_o}, {24'h0, m});
    chk({28'h0, mode_count_o}, {28'h0, c});
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_i, por_i, emu_connected_i, irq_enable_i} = 4'hF;
    {sel_pin1_i, sel_pin0_i, emu_cfg_wr_i, prog_req_i, key_wr_i} = 5'h0;
    gpio_i = 64'h88;
    emu_boot_definition_table_i = 64'h8877665544332211;
    {emu_cfg_data_i, prog_data_i, key_data_i} = 96'h0;
    {prog_addr_i, key_sel_i} = 19'h0;
    mismatches = 0;
    checked = 0;
    tick(12);
    por_i = 1'b0;
    // zone 1 pointer picks region 3 and claims block 0 and sector 0;
    // zone 2 claims shared block 1 and sector 2
    u_otp.mem[0] = 32'hFFFFFFFA;
    u_otp.mem[16'h54] = 32'hFFFFFFFE;
    u_otp.mem[16'h55] = 32'hFFFFFFFE;
    u_otp.mem[16'h405] = 32'hFFFFFFFB;
    for (int i = 0; i < 4; i++)
      u_otp.mem[16'h50 + i] = 32'hC0DE0000 + i;
    u_otp.mem[16'h56] = 32'h5AFFFF07;
    u_otp.mem[16'h57] = 32'hD4C3B2A1;
    u_otp.mem[16'h404] = 32'hFFFFFFFD;
    boot(32'h12345678, 1'b1, 2'h0);
    chk({31'h0, boot_wait_o}, 32'h1);
    chk(32'(boot_flow_o), 32'(FLOW_WAIT));
    chk({30'h0, pie_enable_o, master_int_enable_o}, 32'h0);
    chk(emulation_boot_pin_config_o, 32'h12345678);
    boot(32'h5AFF0503, 1'b1, 2'h0);
    expect_boot(FLOW_EMU, 8'h22, 4'h4);
    chk({10'h0, pc_o}, {10'h0, VEC});
    chk({30'h0, pie_enable_o, master_int_enable_o}, 32'h3);
    boot(32'h5AFFFFFF, 1'b1, 2'h0);
    expect_boot(FLOW_EMU, 8'h11, 4'h1);
    boot(32'hA5000000, 1'b1, 2'h0);
    expect_boot(FLOW_EMU_STANDALONE, 8'hB2, 4'h2);
    boot(32'h0, 1'b0, 2'h0);
    expect_boot(FLOW_STANDALONE_OTP, 8'hB2, 4'h2);
    chk({30'h0, zone_locked_o}, 32'h1);
    chk({30'h0, ls_zone2_o[1:0]}, 32'h2);
    chk({24'h0, ls_secure_o}, 32'h1);
    chk({16'h0, flash_secure_o}, 32'h1);
    chk({16'h0, flash_zone2_o}, 32'h4);
    // matching keys open zone 1
    for (int i = 0; i < 4; i++)
    begin
      key_sel_i = 3'(i);
      key_data_i = 32'hC0DE0000 + i;
      key_wr_i = 1'b1;
      tick(1);
    end
    key_wr_i = 1'b0;
    tick(2);
    chk({30'h0, zone_locked_o}, 32'h0);
    chk({8'h0, ls_secure_o, flash_secure_o}, 32'h0);
    // relocate zone 1 to blank region 4; set bits must stay cleared
    prog_data_i = 32'hFFFFFFF5;
    prog_req_i = 1'b1;
    tick(1);
    prog_req_i = 1'b0;
    tick(8);
    chk(u_otp.mem[0], 32'hFFFFFFF0);
    for (int k = 0; k < 4; k++)
    begin
      boot(32'h0, 1'b0, 2'(k));
      expect_boot(FLOW_STANDALONE_PINS, 8'(k), 4'h4);
      chk({30'h0, zone_locked_o}, 32'h0);
    end
    tally_and_finish;
  end

  // about 460 cycles are needed; give about eleven times that
  initial
  begin
    #(25 * 5000);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule // testbench
